// file: rtl/dac_pkg.sv
package dac_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CSR_AW = 5;
    // Register byte offsets on the Avalon-MM bus
    localparam logic [CSR_AW-1:0] OFS_CONTROL = 5'h00;
    localparam logic [CSR_AW-1:0] OFS_X_START = 5'h04;
    localparam logic [CSR_AW-1:0] OFS_X_END = 5'h08;
    localparam logic [CSR_AW-1:0] OFS_Y_START = 5'h0C;
    localparam logic [CSR_AW-1:0] OFS_Y_END = 5'h10;
    localparam logic [CSR_AW-1:0] OFS_STATUS = 5'h14;
    localparam logic [CSR_AW-1:0] OFS_ERR_ADDR = 5'h18;
    // Control field layout
    localparam int unsigned CTL_XSEL_LO = 0;
    localparam int unsigned CTL_YSEL_LO = 4;
    localparam int unsigned CTL_YEN_BIT = 14;
    localparam int unsigned CTL_XEN_BIT = 15;
    localparam logic [3:0] SEL_NONE = 4'hF;
    localparam logic [15:0] CONTROL_RST = 16'h00FF;
    localparam logic [14:0] START_HI_RST = 15'h0000;
    localparam logic [14:0] END_HI_RST = 15'h7FFF;
    // Fixed low bits of the boundary registers
    localparam logic START_LSB = 1'b0;
    localparam logic END_LSB = 1'b1;
    localparam int unsigned STS_ERR_BIT = 0;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [1:0] BE_LOW = 2'b01;
    localparam logic [1:0] BE_HIGH = 2'b10;
    localparam logic [1:0] BE_WORD = 2'b11;

    typedef enum logic [2:0] {
        DAC_MODE_NONE = 3'h0,
        DAC_MODE_POST_INC = 3'h1,
        DAC_MODE_POST_DEC = 3'h2,
        DAC_MODE_PRE_INC = 3'h3,
        DAC_MODE_PRE_DEC = 3'h4
    } dac_mode_t;

    typedef enum logic [1:0] {
        DAC_BUS_IDLE = 2'b00,
        DAC_BUS_ANSWER = 2'b01
    } dac_bus_t;
endpackage

// file: rtl/dac_top.sv
// What this block does
// - Word accesses drop the address low bit and use the even word.
// - Word data is little-endian: low byte even, high byte odd.
// - Byte accesses pick the byte by low bit, returned on bits 7:0.
// - Word pointer modification steps by two.
// - Word access at odd address raises address error in the same cycle as the access.
// - Misaligned word read completes; misaligned word write is suppressed.
// - Any working register but 15 may be the circular pointer; only it wraps.
// - One circular buffer in X space and one in Y space.
// - Buffers of any length up to 32K words, word or byte data.
// - Boundary checks use word addresses; byte buffers need even length.
// - Start register bit 0 always reads zero.
// - End register bit 0 always reads one.
// - Incrementing pointer past end reloads from the start.
// - Decrementing pointer past start reloads from the end.
// - X wrap active when select is not 15 and bit 15 set.
// - Y wrap active when select is not 15 and bit 14 set.
// - At-or-beyond bound detection; overshoot up to one length corrected.
`timescale 1ns/10ps
`default_nettype none
module dac_top (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [dac_pkg::CSR_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_req_valid,
    input wire logic i_req_y,
    input wire logic [3:0] i_req_reg,
    input wire logic [dac_pkg::ADDR_W-1:0] i_req_ptr,
    input wire logic [2:0] i_req_mode,
    input wire logic i_req_byte,
    input wire logic i_req_write,
    input wire logic [dac_pkg::DATA_W-1:0] i_req_wdata,
    input wire logic [dac_pkg::DATA_W-1:0] i_mem_rdata,
    output logic [dac_pkg::ADDR_W-1:0] o_mem_addr,
    output logic o_mem_re,
    output logic o_mem_we,
    output logic [1:0] o_mem_be,
    output logic [dac_pkg::DATA_W-1:0] o_mem_wdata,
    output logic [dac_pkg::DATA_W-1:0] o_rd_data,
    output logic o_ptr_we,
    output logic [3:0] o_ptr_reg,
    output logic [dac_pkg::ADDR_W-1:0] o_ptr_val,
    output logic o_addr_err,
    output logic o_wrapped
);
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [14:0] xs_ff, nxt_xs, xe_ff, nxt_xe, ys_ff, nxt_ys, ye_ff, nxt_ye;
    logic err_sticky_ff, nxt_err_sticky;
    logic [15:0] err_addr_ff, nxt_err_addr;
    dac_pkg::dac_bus_t bus_ff, nxt_bus;
    logic [31:0] rdata_ff, nxt_rdata;
    logic wait_ff, nxt_wait;

    logic [15:0] addr_ff, nxt_addr;
    logic re_ff, nxt_re, we_ff, nxt_we;
    logic [1:0] be_ff, nxt_be;
    logic [15:0] wdata_ff, nxt_wdata, rd_ff, nxt_rd;
    logic pwe_ff, nxt_pwe;
    logic [3:0] preg_ff, nxt_preg;
    logic [15:0] pval_ff, nxt_pval;
    logic err_ff, nxt_err, wrap_ff, nxt_wrap;
    logic rd_byte_ff, nxt_rd_byte, rd_odd_ff, nxt_rd_odd;

    // Register file views with fixed low bits
    logic [15:0] x_start, x_end, y_start, y_end;
    assign x_start = {xs_ff, dac_pkg::START_LSB};
    assign y_start = {ys_ff, dac_pkg::START_LSB};
    assign x_end = {xe_ff, dac_pkg::END_LSB};
    assign y_end = {ye_ff, dac_pkg::END_LSB};

    logic x_active, y_active;
    assign x_active = ctrl_ff[dac_pkg::CTL_XEN_BIT]
        && (ctrl_ff[dac_pkg::CTL_XSEL_LO +: 4] != dac_pkg::SEL_NONE);
    assign y_active = ctrl_ff[dac_pkg::CTL_YEN_BIT]
        && (ctrl_ff[dac_pkg::CTL_YSEL_LO +: 4] != dac_pkg::SEL_NONE);

    // Avalon-MM slave: fixed one wait cycle, answer at the second edge
    logic bus_req, take;
    assign bus_req = i_avs_read || i_avs_write;
    assign take = bus_req && (bus_ff == dac_pkg::DAC_BUS_ANSWER);

    logic csr_err_set;
    logic [15:0] nxt_addr_raw;

    always_comb begin
        nxt_bus = bus_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        nxt_xs = xs_ff;
        nxt_xe = xe_ff;
        nxt_ys = ys_ff;
        nxt_ye = ye_ff;
        nxt_err_sticky = err_sticky_ff;
        nxt_err_addr = err_addr_ff;
        case (bus_ff)
            dac_pkg::DAC_BUS_IDLE: begin
                if (bus_req) begin
                    nxt_bus = dac_pkg::DAC_BUS_ANSWER;
                    nxt_wait = 1'b0;
                    nxt_rdata = 32'h0000_0000;
                    case (i_avs_address)
                        dac_pkg::OFS_CONTROL: nxt_rdata[15:0] = ctrl_ff;
                        dac_pkg::OFS_X_START: nxt_rdata[15:0] = x_start;
                        dac_pkg::OFS_X_END: nxt_rdata[15:0] = x_end;
                        dac_pkg::OFS_Y_START: nxt_rdata[15:0] = y_start;
                        dac_pkg::OFS_Y_END: nxt_rdata[15:0] = y_end;
                        dac_pkg::OFS_STATUS: nxt_rdata[dac_pkg::STS_ERR_BIT] = err_sticky_ff;
                        dac_pkg::OFS_ERR_ADDR: nxt_rdata[15:0] = err_addr_ff;
                        default: nxt_rdata = 32'h0000_0000;
                    endcase
                end
            end
            dac_pkg::DAC_BUS_ANSWER: begin
                nxt_bus = dac_pkg::DAC_BUS_IDLE;
                if (take && i_avs_write) begin
                    case (i_avs_address)
                        dac_pkg::OFS_CONTROL: begin
                            if (i_avs_byteenable[0]) nxt_ctrl[7:0] = i_avs_writedata[7:0];
                            if (i_avs_byteenable[1]) begin
                                nxt_ctrl[dac_pkg::CTL_XEN_BIT] =
                                    i_avs_writedata[dac_pkg::CTL_XEN_BIT];
                                nxt_ctrl[dac_pkg::CTL_YEN_BIT] =
                                    i_avs_writedata[dac_pkg::CTL_YEN_BIT];
                            end
                        end
                        dac_pkg::OFS_X_START: begin
                            if (i_avs_byteenable[0]) nxt_xs[6:0] = i_avs_writedata[7:1];
                            if (i_avs_byteenable[1]) nxt_xs[14:7] = i_avs_writedata[15:8];
                        end
                        dac_pkg::OFS_X_END: begin
                            if (i_avs_byteenable[0]) nxt_xe[6:0] = i_avs_writedata[7:1];
                            if (i_avs_byteenable[1]) nxt_xe[14:7] = i_avs_writedata[15:8];
                        end
                        dac_pkg::OFS_Y_START: begin
                            if (i_avs_byteenable[0]) nxt_ys[6:0] = i_avs_writedata[7:1];
                            if (i_avs_byteenable[1]) nxt_ys[14:7] = i_avs_writedata[15:8];
                        end
                        dac_pkg::OFS_Y_END: begin
                            if (i_avs_byteenable[0]) nxt_ye[6:0] = i_avs_writedata[7:1];
                            if (i_avs_byteenable[1]) nxt_ye[14:7] = i_avs_writedata[15:8];
                        end
                        dac_pkg::OFS_STATUS: begin
                            if (i_avs_byteenable[0]
                                && i_avs_writedata[dac_pkg::STS_ERR_BIT]) begin
                                nxt_err_sticky = 1'b0;
                            end
                        end
                        default: nxt_err_sticky = err_sticky_ff;
                    endcase
                end
            end
            default: nxt_bus = dac_pkg::DAC_BUS_IDLE;
        endcase
        // New error wins over a clear in the same cycle
        if (csr_err_set) begin
            nxt_err_sticky = 1'b1;
            nxt_err_addr = nxt_addr_raw;
        end
    end

    // Address generation for one pipeline request per cycle
    logic [15:0] step, incd, decd, base_start, base_end, blen, wrapped_ptr, ea_raw;
    logic is_inc, is_dec, is_pre, sel_hit, over_hi, over_lo, wrap_now, misalign;

    always_comb begin
        step = i_req_byte ? dac_pkg::STEP_BYTE : dac_pkg::STEP_WORD;
        incd = i_req_ptr + step;
        decd = i_req_ptr - step;
        is_inc = (i_req_mode == dac_pkg::DAC_MODE_POST_INC)
            || (i_req_mode == dac_pkg::DAC_MODE_PRE_INC);
        is_dec = (i_req_mode == dac_pkg::DAC_MODE_POST_DEC)
            || (i_req_mode == dac_pkg::DAC_MODE_PRE_DEC);
        is_pre = (i_req_mode == dac_pkg::DAC_MODE_PRE_INC)
            || (i_req_mode == dac_pkg::DAC_MODE_PRE_DEC);
        // One buffer per space, pointer chosen by its select field
        base_start = i_req_y ? y_start : x_start;
        base_end = i_req_y ? y_end : x_end;
        sel_hit = i_req_y
            ? (y_active && (i_req_reg == ctrl_ff[dac_pkg::CTL_YSEL_LO +: 4]))
            : (x_active && (i_req_reg == ctrl_ff[dac_pkg::CTL_XSEL_LO +: 4]));
        // Length wraps to zero for a full 32K-word buffer, still exact mod 2^16
        blen = base_end - base_start + dac_pkg::STEP_BYTE;
        // Word-granular at-or-beyond compares
        over_hi = incd[15:1] > base_end[15:1];
        over_lo = decd[15:1] < base_start[15:1];
        wrap_now = sel_hit && ((is_inc && over_hi) || (is_dec && over_lo));
        if (is_inc) begin
            wrapped_ptr = (sel_hit && over_hi) ? incd - blen : incd;
        end else if (is_dec) begin
            wrapped_ptr = (sel_hit && over_lo) ? decd + blen : decd;
        end else begin
            wrapped_ptr = i_req_ptr;
        end
        ea_raw = is_pre ? wrapped_ptr : i_req_ptr;
        misalign = !i_req_byte && ea_raw[0];
        nxt_addr_raw = ea_raw;
    end

    assign csr_err_set = i_req_valid && misalign;

    always_comb begin
        nxt_addr = {ea_raw[15:1], 1'b0};
        nxt_re = i_req_valid && !i_req_write;
        // Y path never writes; misaligned word writes are dropped
        nxt_we = i_req_valid && i_req_write && !i_req_y && !misalign;
        nxt_wdata = i_req_byte ? {i_req_wdata[7:0], i_req_wdata[7:0]} : i_req_wdata;
        if (!i_req_byte) begin
            nxt_be = dac_pkg::BE_WORD;
        end else begin
            nxt_be = ea_raw[0] ? dac_pkg::BE_HIGH : dac_pkg::BE_LOW;
        end
        nxt_pwe = i_req_valid && (is_inc || is_dec);
        nxt_preg = i_req_valid ? i_req_reg : preg_ff;
        nxt_pval = i_req_valid ? wrapped_ptr : pval_ff;
        nxt_err = i_req_valid && misalign;
        nxt_wrap = i_req_valid && wrap_now;
        nxt_rd_byte = i_req_valid ? i_req_byte : rd_byte_ff;
        nxt_rd_odd = i_req_valid ? ea_raw[0] : rd_odd_ff;
        // Read data steered from the access issued one cycle earlier
        if (rd_byte_ff) begin
            nxt_rd = {8'h00, rd_odd_ff ? i_mem_rdata[15:8] : i_mem_rdata[7:0]};
        end else begin
            nxt_rd = i_mem_rdata;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_ff <= dac_pkg::DAC_BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= dac_pkg::CONTROL_RST;
            xs_ff <= dac_pkg::START_HI_RST;
            ys_ff <= dac_pkg::START_HI_RST;
            xe_ff <= dac_pkg::END_HI_RST;
            ye_ff <= dac_pkg::END_HI_RST;
            err_sticky_ff <= 1'b0;
            err_addr_ff <= 16'h0000;
            addr_ff <= 16'h0000;
            re_ff <= 1'b0;
            we_ff <= 1'b0;
            be_ff <= 2'b00;
            wdata_ff <= 16'h0000;
            rd_ff <= 16'h0000;
            pwe_ff <= 1'b0;
            preg_ff <= 4'h0;
            pval_ff <= 16'h0000;
            err_ff <= 1'b0;
            wrap_ff <= 1'b0;
            rd_byte_ff <= 1'b0;
            rd_odd_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            xs_ff <= nxt_xs;
            ys_ff <= nxt_ys;
            xe_ff <= nxt_xe;
            ye_ff <= nxt_ye;
            err_sticky_ff <= nxt_err_sticky;
            err_addr_ff <= nxt_err_addr;
            addr_ff <= nxt_addr;
            re_ff <= nxt_re;
            we_ff <= nxt_we;
            be_ff <= nxt_be;
            wdata_ff <= nxt_wdata;
            rd_ff <= nxt_rd;
            pwe_ff <= nxt_pwe;
            preg_ff <= nxt_preg;
            pval_ff <= nxt_pval;
            err_ff <= nxt_err;
            wrap_ff <= nxt_wrap;
            rd_byte_ff <= nxt_rd_byte;
            rd_odd_ff <= nxt_rd_odd;
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_mem_addr = addr_ff;
    assign o_mem_re = re_ff;
    assign o_mem_we = we_ff;
    assign o_mem_be = be_ff;
    assign o_mem_wdata = wdata_ff;
    assign o_rd_data = rd_ff;
    assign o_ptr_we = pwe_ff;
    assign o_ptr_reg = preg_ff;
    assign o_ptr_val = pval_ff;
    assign o_addr_err = err_ff;
    assign o_wrapped = wrap_ff;

    default clocking dac_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    AST_WORD_EVEN: assert property ($past(i_req_valid) && !$past(i_req_byte)
        |-> !o_mem_addr[0] && o_mem_be == dac_pkg::BE_WORD)
        else $error("Word access not on even address");
    // Read data trails the request by two edges
    AST_BYTE_LANE: assert property ($past(i_req_valid, 2) && $past(i_req_byte, 2)
        |-> o_rd_data[15:8] == 8'h00)
        else $error("Byte read data above bit 7");
    AST_WORD_STEP: assert property (i_req_valid && !i_req_byte && !sel_hit
        && i_req_mode == dac_pkg::DAC_MODE_POST_INC
        |=> o_ptr_we && o_ptr_val == $past(i_req_ptr) + dac_pkg::STEP_WORD)
        else $error("Word post-increment not by two");
    AST_BYTE_STEP: assert property (i_req_valid && i_req_byte && !sel_hit
        && i_req_mode == dac_pkg::DAC_MODE_POST_DEC
        |=> o_ptr_val == $past(i_req_ptr) - dac_pkg::STEP_BYTE)
        else $error("Byte post-decrement not by one");
    AST_MISALIGN_ERR: assert property (i_req_valid && !i_req_byte && i_req_ptr[0]
        && i_req_mode == dac_pkg::DAC_MODE_NONE |=> o_addr_err && err_sticky_ff)
        else $error("Misaligned word access not flagged");
    AST_NO_BAD_WRITE: assert property (o_addr_err |-> !o_mem_we)
        else $error("Misaligned word write reached memory");
    AST_START_LSB: assert property (!x_start[0] && !y_start[0])
        else $error("Start register low bit not zero");
    AST_END_LSB: assert property (x_end[0] && y_end[0])
        else $error("End register low bit not one");
    AST_INC_WRAP: assert property (i_req_valid && sel_hit && !i_req_y && !i_req_byte
        && i_req_mode == dac_pkg::DAC_MODE_POST_INC && i_req_ptr == {x_end[15:1], 1'b0}
        |=> o_wrapped && o_ptr_val == $past(x_start))
        else $error("Incrementing pointer did not reload start");
    AST_DEC_WRAP: assert property (i_req_valid && sel_hit && !i_req_byte
        && i_req_mode == dac_pkg::DAC_MODE_POST_DEC && i_req_ptr == base_start
        |=> o_wrapped && o_ptr_val == $past(base_end) - dac_pkg::STEP_BYTE)
        else $error("Decrementing pointer did not reload end");
    AST_SP_NEVER: assert property (i_req_valid && i_req_reg == dac_pkg::SEL_NONE
        |=> !o_wrapped)
        else $error("Stack pointer was wrapped");
    AST_BUS_ANSWER: assert property (bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Bus answer missing");
    COV_WRAP: cover property (o_wrapped);
    COV_ERR: cover property (o_addr_err ##1 err_sticky_ff);
    COV_BYTE_HI: cover property (o_mem_re && o_mem_be == dac_pkg::BE_HIGH);
endmodule // dac_top
`default_nettype wire

// file: testbench/dac_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module dac_pipe_model (
    input wire logic i_clock,
    input wire logic [15:0] i_mem_addr,
    input wire logic i_mem_re,
    input wire logic i_mem_we,
    input wire logic [1:0] i_mem_be,
    input wire logic [15:0] i_mem_wdata,
    output logic [15:0] o_mem_rdata,
    output logic o_req_valid,
    output logic o_req_y,
    output logic [3:0] o_req_reg,
    output logic [15:0] o_req_ptr,
    output logic [2:0] o_req_mode,
    output logic o_req_byte,
    output logic o_req_write,
    output logic [15:0] o_req_wdata
);
    logic [15:0] mem [0:255];
    logic [15:0] junk = 16'hA5C3;
    logic re_d = 1'b0;
    logic [7:0] idx_d = 8'h00;
    initial begin
        {o_req_valid, o_req_y, o_req_reg, o_req_ptr, o_req_mode} = '0;
        {o_req_byte, o_req_write, o_req_wdata} = '0;
    end
    always @(posedge i_clock) begin
        junk <= ~{junk[14:0], junk[15]};
        re_d <= i_mem_re;
        idx_d <= i_mem_addr[8:1];
        if (i_mem_we && i_mem_be[0]) mem[i_mem_addr[8:1]][7:0] <= i_mem_wdata[7:0];
        if (i_mem_we && i_mem_be[1]) mem[i_mem_addr[8:1]][15:8] <= i_mem_wdata[15:8];
    end
    // Moving pattern outside a read and the cycle after it, which holds the read data
    assign o_mem_rdata = i_mem_re ? mem[i_mem_addr[8:1]] : (re_d ? mem[idx_d] : junk);
    task automatic issue(input logic y, input logic [3:0] rg, input logic [15:0] ptr,
            input logic [2:0] md, input logic bsz, input logic wr, input logic [15:0] wd);
        @(posedge i_clock);
        o_req_valid <= 1'b1;
        o_req_y <= y;
        o_req_reg <= rg;
        o_req_ptr <= ptr;
        o_req_mode <= md;
        o_req_byte <= bsz & ~y;
        o_req_write <= wr;
        o_req_wdata <= wd;
        @(posedge i_clock);
        o_req_valid <= 1'b0;
        o_req_ptr <= ~ptr;
    endtask
endmodule // dac_pipe_model
`default_nettype wire

// file: testbench/test_dac_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_dac_top;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [4:0] i_avs_address = 5'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h00000000;
    logic [3:0] i_avs_byteenable = 4'h0;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest, i_req_valid, i_req_y, i_req_byte, i_req_write, o_mem_re, o_mem_we;
    logic o_ptr_we, o_addr_err, o_wrapped;
    logic [3:0] i_req_reg, o_ptr_reg;
    logic [2:0] i_req_mode;
    logic [1:0] o_mem_be;
    logic [15:0] i_req_ptr, i_req_wdata, i_mem_rdata, o_mem_addr, o_mem_wdata, o_rd_data, o_ptr_val;
    int error_cnt = 0;
    int n_checks = 0;

    always #4 i_clock = ~i_clock;

    dac_top i_dut (
        .i_clock, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_req_valid, .i_req_y,
        .i_req_reg, .i_req_ptr, .i_req_mode, .i_req_byte, .i_req_write, .i_req_wdata,
        .i_mem_rdata, .o_mem_addr, .o_mem_re, .o_mem_we, .o_mem_be, .o_mem_wdata, .o_rd_data,
        .o_ptr_we, .o_ptr_reg, .o_ptr_val, .o_addr_err, .o_wrapped
    );
    dac_pipe_model i_model (
        .i_clock, .i_mem_addr(o_mem_addr), .i_mem_re(o_mem_re), .i_mem_we(o_mem_we),
        .i_mem_be(o_mem_be), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata),
        .o_req_valid(i_req_valid), .o_req_y(i_req_y), .o_req_reg(i_req_reg),
        .o_req_ptr(i_req_ptr), .o_req_mode(i_req_mode), .o_req_byte(i_req_byte),
        .o_req_write(i_req_write), .o_req_wdata(i_req_wdata)
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] wd,
            output logic [31:0] rd);
        @(posedge i_clock);
        i_avs_address <= a;
        i_avs_writedata <= {16'h0000, wd};
        i_avs_byteenable <= 4'h3;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        // Values read here are those sampled at this edge; watchdog ends a hang
        do begin
            @(posedge i_clock);
        end while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 16'h0000, rd);
        chk(rd, exp);
    endtask

    task automatic go(input logic y, input logic [3:0] rg, input logic [15:0] ptr,
            input logic [2:0] md, input logic bsz, input logic wr, input logic [15:0] wd);
        i_model.issue(y, rg, ptr, md, bsz, wr, wd);
        #1;
    endtask

    task automatic step();
        @(posedge i_clock);
        #1;
    endtask

    function automatic logic [6:0] fl();
        return {o_mem_re, o_mem_we, o_mem_be, o_ptr_we, o_addr_err, o_wrapped};
    endfunction

    task automatic t_regs();
        rchk(dac_pkg::OFS_CONTROL, 32'h000000FF);
        rchk(dac_pkg::OFS_X_START, 32'h00000000);
        rchk(dac_pkg::OFS_Y_END, 32'h0000FFFF);
        wreg(dac_pkg::OFS_X_START, 16'h1201);
        wreg(dac_pkg::OFS_X_END, 16'h121E);
        wreg(dac_pkg::OFS_Y_START, 16'h1301);
        wreg(dac_pkg::OFS_Y_END, 16'h13FE);
        rchk(dac_pkg::OFS_X_START, 32'h00001200);
        rchk(dac_pkg::OFS_X_END, 32'h0000121F);
        rchk(dac_pkg::OFS_Y_START, 32'h00001300);
        rchk(dac_pkg::OFS_Y_END, 32'h000013FF);
        wreg(5'h1C, 16'hBEEF);
        rchk(5'h1C, 32'h00000000);
    endtask

    task automatic t_align();
        i_model.mem[0] = 16'hB2A1;
        i_model.mem[1] = 16'hD4C3;
        i_model.mem[2] = 16'hF6E5;
        go(0, 4'h1, 16'h1000, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({fl(), o_mem_addr, o_ptr_val}, {7'b1011100, 16'h1000, 16'h1002});
        step();
        chk(o_rd_data, 16'hB2A1);
        go(0, 4'h2, 16'h1003, dac_pkg::DAC_MODE_POST_DEC, 1, 0, 16'h0000);
        chk({fl(), o_mem_addr, o_ptr_val}, {7'b1010100, 16'h1002, 16'h1002});
        step();
        chk(o_rd_data, 16'h00D4);
        go(0, 4'h2, 16'h1004, dac_pkg::DAC_MODE_NONE, 1, 0, 16'h0000);
        step();
        chk(o_rd_data, 16'h00E5);
        go(0, 4'h3, 16'h1005, dac_pkg::DAC_MODE_NONE, 0, 0, 16'h0000);
        chk({fl(), o_mem_addr}, {7'b1011010, 16'h1004});
        step();
        chk(o_rd_data, 16'hF6E5);
        go(0, 4'h3, 16'h1005, dac_pkg::DAC_MODE_POST_INC, 0, 1, 16'h1234);
        chk({o_mem_we, o_addr_err, o_ptr_val}, {2'b01, 16'h1007});
        step();
        chk(i_model.mem[2], 16'hF6E5);
        go(0, 4'h3, 16'h1004, dac_pkg::DAC_MODE_POST_DEC, 0, 1, 16'h1234);
        chk({fl(), o_mem_wdata, o_ptr_val}, {7'b0111100, 16'h1234, 16'h1002});
        go(0, 4'h3, 16'h1005, dac_pkg::DAC_MODE_NONE, 1, 1, 16'h0077);
        chk({fl(), o_mem_addr}, {7'b0110000, 16'h1004});
        step();
        chk(i_model.mem[2], 16'h7734);
        rchk(dac_pkg::OFS_STATUS, 32'h00000001);
        rchk(dac_pkg::OFS_ERR_ADDR, 32'h00001005);
        wreg(dac_pkg::OFS_STATUS, 16'h0001);
        rchk(dac_pkg::OFS_STATUS, 32'h00000000);
    endtask

    task automatic t_circ_x();
        wreg(dac_pkg::OFS_CONTROL, 16'h80F4);
        step(); // Idle after control write
        go(0, 4'h4, 16'h121E, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_reg, o_ptr_val, o_mem_addr}, {5'h14, 16'h1200, 16'h121E});
        go(0, 4'h5, 16'h121E, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h1220});
        go(1, 4'h4, 16'h121E, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h1220});
        go(0, 4'h4, 16'h121E, dac_pkg::DAC_MODE_PRE_INC, 0, 0, 16'h0000);
        chk({o_ptr_val, o_mem_addr}, {16'h1200, 16'h1200});
        go(0, 4'h4, 16'h121E, dac_pkg::DAC_MODE_POST_INC, 1, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h121F});
        go(0, 4'h4, 16'h121F, dac_pkg::DAC_MODE_POST_INC, 1, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b1, 16'h1200});
        go(0, 4'h4, 16'h1230, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk(o_ptr_val, 16'h1212);
        wreg(dac_pkg::OFS_X_START, 16'h0000);
        wreg(dac_pkg::OFS_X_END, 16'h7FFF);
        step(); // Idle after bound write
        go(0, 4'h4, 16'h7FFE, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b1, 16'h0000});
        wreg(dac_pkg::OFS_CONTROL, 16'h80FF);
        step();
        go(0, 4'hF, 16'h7FFE, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h8000});
        wreg(dac_pkg::OFS_CONTROL, 16'h00F4);
        step();
        go(0, 4'h4, 16'h7FFE, dac_pkg::DAC_MODE_POST_INC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h8000});
    endtask

    task automatic t_circ_y();
        wreg(dac_pkg::OFS_CONTROL, 16'hC0A4);
        step();
        go(1, 4'hA, 16'h1300, dac_pkg::DAC_MODE_POST_DEC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val, o_mem_addr}, {1'b1, 16'h13FE, 16'h1300});
        go(1, 4'hA, 16'h1300, dac_pkg::DAC_MODE_PRE_DEC, 0, 0, 16'h0000);
        chk({o_ptr_val, o_mem_addr}, {16'h13FE, 16'h13FE});
        go(0, 4'hA, 16'h1300, dac_pkg::DAC_MODE_POST_DEC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h12FE});
        go(1, 4'h4, 16'h1300, dac_pkg::DAC_MODE_POST_DEC, 0, 0, 16'h0000);
        chk({o_wrapped, o_ptr_val}, {1'b0, 16'h12FE});
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge i_clock);
        i_rstn <= 1'b1;
        t_regs();
        t_align();
        t_circ_x();
        t_circ_y();
        results();
    end

    initial begin
        #50000;
        error_cnt++;
        results();
    end
endmodule // test_dac_top
`default_nettype wire
